// ==== hdl/irq_dma_sequencer.sv ====
// Interrupt acceptance sequencer with hardware micro DMA for an 8-bit core.
// Assumes all inputs are synchronous to clk, and that the memory bus returns
// read data in the cycle after the read strobe.
`timescale 1ns/10ps

module irq_dma_sequencer (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Requests from sources: 0 software trap, 1 pin, 2..9 maskable.
    input wire logic [irq_seq_pkg::NUM_SRC-1:0] irq_req,
    // Core instruction events.
    input wire logic instr_boundary,
    input wire logic enable_irq_instr,
    input wire logic disable_irq_instr,
    input wire logic return_from_irq_instr,
    // Core register values.
    input wire logic [15:0] cpu_pc,
    input wire logic [15:0] accumulator_flag_pair,
    input wire logic [15:0] cpu_sp,
    // Core register updates.
    output logic pc_load,
    output logic [15:0] pc_value,
    output logic af_load,
    output logic [15:0] af_value,
    output logic sp_load,
    output logic [15:0] sp_value,
    output logic irq_enable_flag,
    output logic busy,
    // Acknowledge to sources.
    output logic [irq_seq_pkg::NUM_SRC-1:0] irq_ack,
    output logic [7:0] ack_vector,
    // Memory bus master.
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic mem_wr,
    output logic mem_rd,
    input wire logic [7:0] mem_rdata,
    // Register port.
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);
    import irq_seq_pkg::*;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ENTRY = 4'h2,
        ST_DMA = 4'h4,
        ST_RETURN = 4'h8
    } seq_state_t;

    typedef struct packed {
        seq_state_t state;
        logic [5:0] step;
        logic [7:0] vector;
        logic [15:0] save_pc;
        logic [15:0] save_af;
        logic [15:0] sp;
        logic [7:0] count;
        logic [15:0] dst;
        logic [15:0] src;
        logic [2:0] mode;
        logic [7:0] data;
        logic flag;
        logic [NUM_MASKABLE-1:0] dma_en;
        logic [15:0] mem_addr;
        logic [7:0] mem_wdata;
        logic mem_wr;
        logic mem_rd;
        logic [NUM_SRC-1:0] ack;
        logic pc_load;
        logic [15:0] pc_value;
        logic af_load;
        logic [15:0] af_value;
        logic sp_load;
        logic [15:0] sp_value;
        logic busy;
        logic [7:0] rdata;
    } seq_regs_t;

    seq_regs_t r_reg;
    seq_regs_t r_next;

    // ---------------------------------------------------------------
    // Arbitration
    // ---------------------------------------------------------------
    logic [NUM_SRC-1:0] eligible;
    logic [NUM_SRC-1:0] winner;
    logic any_win;
    logic [3:0] win_idx;

    // Mask the maskable sources with the flag as it stood before this cycle,
    // so an enable issued at this boundary only counts from the next one.
    always_comb begin
        eligible = irq_req;
        if (!r_reg.flag) begin
            eligible[NUM_SRC-1:FIRST_MASKABLE] = '0;
        end
    end

    // Fixed order: lowest index wins; nothing here sees the source in service.
    always_comb begin
        winner = '0;
        win_idx = 4'h0;
        any_win = 1'b0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                winner = '0;
                winner[i] = 1'b1;
                win_idx = 4'(i);
                any_win = 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    logic [7:0] win_vector;
    logic win_is_dma;
    logic [15:0] block_addr;
    logic [2:0] param_ofs;
    logic wide;
    logic [15:0] step_amt;
    logic [7:0] count_dec;
    logic [39:0] wb_bytes;
    logic [2:0] wb_idx;

    always_comb begin
        r_next = r_reg;
        win_vector = 8'(VECTOR_BASE + 8'(win_idx) * VECTOR_STEP);
        win_is_dma = 1'b0;
        if (win_idx >= 4'(FIRST_MASKABLE)) begin
            win_is_dma = r_reg.dma_en[3'(win_idx - 4'(FIRST_MASKABLE))];
        end
        block_addr = PARAM_BASE + {8'h00, r_reg.vector};
        param_ofs = 3'(r_reg.step - READ_LATENCY);
        wide = r_reg.mode[MODE_WIDE_BIT];
        step_amt = wide ? 16'h0002 : 16'h0001;
        count_dec = 8'(r_reg.count - 8'h01);
        wb_bytes = {r_reg.src, r_reg.dst, count_dec};
        wb_idx = 3'(r_reg.step - 6'h0E);

        // Strobes and load pulses last one cycle.
        r_next.mem_wr = 1'b0;
        r_next.mem_rd = 1'b0;
        r_next.ack = '0;
        r_next.pc_load = 1'b0;
        r_next.af_load = 1'b0;
        r_next.sp_load = 1'b0;
        r_next.step = 6'(r_reg.step + 6'h01);

        // Register port: read data stands the cycle after the strobe.
        r_next.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                REG_DMA_ENABLE: r_next.rdata = r_reg.dma_en;
                REG_STATUS: r_next.rdata = {r_reg.state, 2'b00, r_reg.busy, r_reg.flag};
                REG_PENDING_LO: r_next.rdata = irq_req[7:0];
                REG_PENDING_HI: r_next.rdata = {6'h00, irq_req[9:8]};
                default: r_next.rdata = 8'h00;
            endcase
        end
        if (reg_wr && reg_addr == REG_DMA_ENABLE) begin
            r_next.dma_en = reg_wdata;
        end

        // Flag instructions; a later accept into general entry below overrides with a clear.
        if (enable_irq_instr) begin
            r_next.flag = 1'b1;
        end
        if (disable_irq_instr) begin
            r_next.flag = 1'b0;
        end

        case (r_reg.state)
            ST_IDLE: begin
                r_next.step = 6'h00;
                r_next.busy = 1'b0;
                if (return_from_irq_instr) begin
                    r_next.state = ST_RETURN;
                    r_next.sp = cpu_sp;
                    r_next.busy = 1'b1;
                end else if (instr_boundary && any_win) begin
                    // Vector read: the source takes this as its acknowledge.
                    r_next.ack = winner;
                    r_next.vector = win_vector;
                    r_next.sp = cpu_sp;
                    r_next.busy = 1'b1;
                    if (win_is_dma) begin
                        r_next.state = ST_DMA;
                    end else begin
                        r_next.state = ST_ENTRY;
                        r_next.save_pc = cpu_pc;
                        r_next.save_af = accumulator_flag_pair;
                        r_next.save_af[FLAG_BIT] = r_reg.flag;
                        r_next.flag = 1'b0;
                    end
                end
            end

            ST_ENTRY: begin
                // Push PC high, PC low, A, then F below the stack pointer.
                case (r_reg.step)
                    6'h00: begin
                        r_next.mem_wr = 1'b1;
                        r_next.mem_addr = 16'(r_reg.sp - 16'h0001);
                        r_next.mem_wdata = r_reg.save_pc[15:8];
                    end
                    6'h01: begin
                        r_next.mem_wr = 1'b1;
                        r_next.mem_addr = 16'(r_reg.sp - 16'h0002);
                        r_next.mem_wdata = r_reg.save_pc[7:0];
                    end
                    6'h02: begin
                        r_next.mem_wr = 1'b1;
                        r_next.mem_addr = 16'(r_reg.sp - 16'h0003);
                        r_next.mem_wdata = r_reg.save_af[15:8];
                    end
                    6'h03: begin
                        r_next.mem_wr = 1'b1;
                        r_next.mem_addr = 16'(r_reg.sp - 16'h0004);
                        r_next.mem_wdata = r_reg.save_af[7:0];
                    end
                    default: begin
                    end
                endcase
                // Jump to the vector once the full entry time has passed.
                if (r_reg.step == 6'(ENTRY_STATES - 6'h02)) begin
                    r_next.pc_load = 1'b1;
                    r_next.pc_value = {8'h00, r_reg.vector};
                    r_next.sp_load = 1'b1;
                    r_next.sp_value = 16'(r_reg.sp - 16'h0004);
                    r_next.state = ST_IDLE;
                    r_next.busy = 1'b0;
                end
            end

            ST_DMA: begin
                // Parameter reads issue at steps 0..5, data returns two later.
                if (r_reg.step < 6'(PARAM_LEN)) begin
                    r_next.mem_rd = 1'b1;
                    r_next.mem_addr = 16'(block_addr + {10'h000, r_reg.step});
                end
                if (r_reg.step >= READ_LATENCY && r_reg.step < 6'(PARAM_LEN) + READ_LATENCY) begin
                    case (param_ofs)
                        OFS_COUNT: r_next.count = mem_rdata;
                        OFS_DST_LO: r_next.dst[7:0] = mem_rdata;
                        OFS_DST_HI: r_next.dst[15:8] = mem_rdata;
                        OFS_SRC_LO: r_next.src[7:0] = mem_rdata;
                        OFS_SRC_HI: r_next.src[15:8] = mem_rdata;
                        OFS_MODE: r_next.mode = mem_rdata[2:0];
                        default: begin
                        end
                    endcase
                end
                case (r_reg.step)
                    6'h08: begin
                        r_next.mem_rd = 1'b1;
                        r_next.mem_addr = r_reg.src;
                    end
                    6'h0A: begin
                        r_next.mem_wr = 1'b1;
                        r_next.mem_addr = r_reg.dst;
                        r_next.mem_wdata = mem_rdata;
                    end
                    6'h0B: begin
                        if (wide) begin
                            r_next.mem_rd = 1'b1;
                            r_next.mem_addr = 16'(r_reg.src + 16'h0001);
                        end
                    end
                    6'h0D: begin
                        if (wide) begin
                            r_next.mem_wr = 1'b1;
                            r_next.mem_addr = 16'(r_reg.dst + 16'h0001);
                            r_next.mem_wdata = mem_rdata;
                        end
                        // Address update only after both bytes have moved.
                        case (r_reg.mode[1:0])
                            UPD_DST_INC: r_next.dst = 16'(r_reg.dst + step_amt);
                            UPD_SRC_INC: r_next.src = 16'(r_reg.src + step_amt);
                            UPD_SRC_DEC: r_next.src = 16'(r_reg.src - step_amt);
                            default: begin
                            end
                        endcase
                    end
                    6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12: begin
                        // Write back the new count, then the updated addresses.
                        r_next.mem_wr = 1'b1;
                        r_next.mem_addr = block_addr + {13'h0000, wb_idx};
                        r_next.mem_wdata = wb_bytes[8 * wb_idx +: 8];
                    end
                    default: begin
                    end
                endcase
                // End of service: done, or hand over to the general entry.
                if (r_reg.step == 6'(DMA_STATES - 6'h02)) begin
                    r_next.step = 6'h00;
                    if (count_dec == 8'h00) begin
                        r_next.state = ST_ENTRY;
                        r_next.save_pc = cpu_pc;
                        r_next.save_af = accumulator_flag_pair;
                        r_next.save_af[FLAG_BIT] = r_reg.flag;
                        r_next.flag = 1'b0;
                    end else begin
                        r_next.state = ST_IDLE;
                        r_next.busy = 1'b0;
                    end
                end
            end

            ST_RETURN: begin
                // Pop F, A, PC low, PC high from the stack pointer upward.
                if (r_reg.step < 6'h04) begin
                    r_next.mem_rd = 1'b1;
                    r_next.mem_addr = 16'(r_reg.sp + {10'h000, r_reg.step});
                end
                case (r_reg.step)
                    6'h02: r_next.af_value[7:0] = mem_rdata;
                    6'h03: r_next.af_value[15:8] = mem_rdata;
                    6'h04: r_next.pc_value[7:0] = mem_rdata;
                    6'h05: r_next.pc_value[15:8] = mem_rdata;
                    default: begin
                    end
                endcase
                if (r_reg.step == 6'(RETURN_STATES - 6'h02)) begin
                    r_next.flag = r_reg.af_value[FLAG_BIT];
                    r_next.pc_load = 1'b1;
                    r_next.af_load = 1'b1;
                    r_next.sp_load = 1'b1;
                    r_next.sp_value = 16'(r_reg.sp + 16'h0004);
                    r_next.state = ST_IDLE;
                    r_next.busy = 1'b0;
                end
            end

            default: begin
                r_next.state = ST_IDLE;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    // Synchronous reset clears the flag and all DMA enables.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            r_reg <= '0;
            r_reg.state <= ST_IDLE;
            r_reg.flag <= 1'b0;
            r_reg.dma_en <= DMA_ENABLE_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // ---------------------------------------------------------------
    // Outputs, all straight from the state register
    // ---------------------------------------------------------------
    assign pc_load = r_reg.pc_load;
    assign pc_value = r_reg.pc_value;
    assign af_load = r_reg.af_load;
    assign af_value = r_reg.af_value;
    assign sp_load = r_reg.sp_load;
    assign sp_value = r_reg.sp_value;
    assign irq_enable_flag = r_reg.flag;
    assign busy = r_reg.busy;
    assign irq_ack = r_reg.ack;
    assign ack_vector = r_reg.vector;
    assign mem_addr = r_reg.mem_addr;
    assign mem_wdata = r_reg.mem_wdata;
    assign mem_wr = r_reg.mem_wr;
    assign mem_rd = r_reg.mem_rd;
    assign reg_rdata = r_reg.rdata;

endmodule : irq_dma_sequencer

// ==== pkg/irq_seq_pkg.sv ====
// Constants shared by the interrupt acceptance and micro DMA sequencer.
// Assumes one state of the core equals one clock cycle of clk.
//
// How it works
// - Entry pushes PC and accumulator/flag pair, clears enable flag, jumps to vector.
// - General entry takes exactly 20 states.
// - Return instruction pops PC and pair, restoring the old enable flag.
// - Reading the vector acknowledges the source, which then drops its request.
// - Non-maskable sources ignore the enable flag; maskable ones need flag bit 5.
// - Enable sets flag, disable clears it; reset and any general entry clear it.
// - Maskable requests wait until the instruction after enable has completed.
// - Vectors run from 10H to 58H in steps of 8; maskable ones have blocks.
// - Simultaneous requests are taken in a fixed ten-level order.
// - Arbitration looks only at pending requests, never at the one in service.
// - DMA loads parameters, moves data, writes back, decrements count, usually ends.
// - When the count reaches zero, general entry follows for the same source.
// - A DMA service that does not reach zero leaves PC, flag and all core registers untouched.
// - Parameter block sits at FF00H plus vector and spans six bytes.
// - A stored count of 00H means 256 transfers.
// - Source and destination are full 16-bit addresses.
// - Mode bits 1:0 choose address update, bit 2 chooses one or two bytes.
// - Modes: keep, destination up, source up or source down, by 1 or 2.
// - Two-byte mode copies src to dst, then src+1 to dst+1.
// - A DMA service that does not reach zero lasts 46 states.
// - Requests are sampled only at the last bus cycle of each instruction.
// - Maskable requests are ignored while the enable flag is 0.
// - Per-channel DMA enable selects DMA when 1; reset clears it.

package irq_seq_pkg;

    // -------------------------------------------------------------
    // Sources and vectors
    // -------------------------------------------------------------
    localparam int NUM_SRC = 10;
    localparam int NUM_MASKABLE = 8;
    localparam int FIRST_MASKABLE = 2;
    localparam logic [7:0] VECTOR_BASE = 8'h10;
    localparam logic [7:0] VECTOR_STEP = 8'h08;
    localparam int FLAG_BIT = 5;

    // -------------------------------------------------------------
    // Micro DMA parameter block
    // -------------------------------------------------------------
    localparam logic [15:0] PARAM_BASE = 16'hFF00;
    localparam int PARAM_LEN = 6;
    localparam logic [2:0] OFS_COUNT = 3'h0;
    localparam logic [2:0] OFS_DST_LO = 3'h1;
    localparam logic [2:0] OFS_DST_HI = 3'h2;
    localparam logic [2:0] OFS_SRC_LO = 3'h3;
    localparam logic [2:0] OFS_SRC_HI = 3'h4;
    localparam logic [2:0] OFS_MODE = 3'h5;
    localparam int MODE_WIDE_BIT = 2;
    localparam logic [1:0] UPD_KEEP = 2'h0;
    localparam logic [1:0] UPD_DST_INC = 2'h1;
    localparam logic [1:0] UPD_SRC_INC = 2'h2;
    localparam logic [1:0] UPD_SRC_DEC = 2'h3;

    // -------------------------------------------------------------
    // Timing in states (one state = one clk cycle)
    // -------------------------------------------------------------
    localparam logic [5:0] ENTRY_STATES = 6'h14;
    localparam logic [5:0] DMA_STATES = 6'h2E;
    localparam logic [5:0] RETURN_STATES = 6'h08;
    localparam logic [5:0] READ_LATENCY = 6'h02;

    // -------------------------------------------------------------
    // Register port map
    // -------------------------------------------------------------
    localparam logic [1:0] REG_DMA_ENABLE = 2'h0;
    localparam logic [1:0] REG_STATUS = 2'h1;
    localparam logic [1:0] REG_PENDING_LO = 2'h2;
    localparam logic [1:0] REG_PENDING_HI = 2'h3;
    localparam logic [7:0] DMA_ENABLE_RESET = 8'h00;

endpackage : irq_seq_pkg

// ==== test/interrupt_and_micro_dma_sequencer_tb.sv ====
// Bench comparing the sequencer with a model of the rules.
// Assumes the source model and the checker are compiled first.
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
`define WAIT(c) n = 0; while ((c) !== 1'b1 && n < 99) begin @(posedge clk); #1; n++; end
module interrupt_and_micro_dma_sequencer_tb;
    import irq_seq_pkg::*;
    // ------------------------------------------------------------
    // Stimulus, wiring and tasks
    // ------------------------------------------------------------
    logic clk = 1'b0, nrst = 1'b0, instr_boundary = 1'b0, enable_irq_instr = 1'b0;
    logic disable_irq_instr = 1'b0, return_from_irq_instr = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [15:0] cpu_pc = 16'h0000, accumulator_flag_pair = 16'h0000, cpu_sp = 16'h0000;
    logic [NUM_SRC-1:0] raise = 10'h000, irq_req, irq_ack;
    logic [15:0] pc_value, af_value, sp_value, mem_addr;
    logic [7:0] ack_vector, mem_wdata, mem_rdata, reg_wdata = 8'h00, reg_rdata, rd;
    logic [1:0] reg_addr = 2'h0;
    logic pc_load, af_load, sp_load, irq_enable_flag, busy, mem_wr, mem_rd;
    int bad_count = 0, samples_checked = 0, seed = 32'h7674, n;
    irq_dma_sequencer dut_u (.*);
    irq_src_model src_u (.*);
    // Clock of 40 ns and a watchdog far beyond the expected run.
    always #20 clk = ~clk;
    initial begin
        #400000;
        bad_count++;
        report_and_stop();
    end
    // Six bytes of memory, lowest address first.
    function automatic logic [47:0] peek(input logic [15:0] a);
        logic [47:0] r;
        for (int i = 0; i < 6; i++) r = {r[39:0], src_u.mem[a + i]};
        return r;
    endfunction : peek
    // Raises requests, optionally enables, then ends an instruction.
    task automatic fire(input logic [9:0] r, input logic en);
        @(posedge clk);
        raise <= r;
        enable_irq_instr <= en;
        @(posedge clk);
        raise <= 10'h000;
        enable_irq_instr <= 1'b0;
        instr_boundary <= 1'b1;
        @(posedge clk);
        instr_boundary <= 1'b0;
        #1;
    endtask : fire
    // Register read; data land in rd.
    task automatic reg_read(input logic [1:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask : reg_read
    // Entry of source b with checks of the stack, then the return.
    task automatic serve(input logic [9:0] r, input int b, input logic old, input logic en);
        logic [7:0] f, v;
        logic [15:0] s;
        @(posedge clk);
        cpu_pc <= 16'($random(seed));
        accumulator_flag_pair <= 16'($random(seed));
        cpu_sp <= {2'h1, 14'($random(seed))};
        fire(r, en);
        v = 8'(VECTOR_BASE + VECTOR_STEP * b);
        `CHK({irq_ack, ack_vector}, {10'h001 << b, v})
        f = {accumulator_flag_pair[7:6], old, accumulator_flag_pair[4:0]};
        s = cpu_sp - 16'h0004;
        `WAIT(pc_load)
        `CHK({pc_value, sp_value, irq_enable_flag}, {8'h00, v, s, 1'b0})
        `CHK(peek(s) >> 16, {f, accumulator_flag_pair[15:8], cpu_pc[7:0], cpu_pc[15:8]})
        @(posedge clk);
        cpu_sp <= s;
        return_from_irq_instr <= 1'b1;
        @(posedge clk);
        return_from_irq_instr <= 1'b0;
        #1;
        `WAIT(af_load)
        `CHK({pc_value, af_value, sp_value, irq_enable_flag},
            {cpu_pc, accumulator_flag_pair[15:8], f, s + 16'h0004, old})
    endtask : serve
    // One micro DMA service on channel b with mode m and count c.
    task automatic dma(input int b, input logic [2:0] m, input logic [7:0] c);
        logic [15:0] blk, src, dst, w;
        logic [7:0] d0, d1, v;
        logic [47:0] p;
        logic seen;
        v = 8'(VECTOR_BASE + VECTOR_STEP * b);
        blk = PARAM_BASE + {8'h00, v};
        src = {4'h1, 12'($random(seed))};
        dst = {4'h2, 12'($random(seed))};
        {d0, d1} = 16'($random(seed));
        {src_u.mem[src], src_u.mem[src + 16'h1], src_u.mem[dst + 16'h1]} = {d0, d1, ~d1};
        p = {c, dst[7:0], dst[15:8], src[7:0], src[15:8], 5'h00, m};
        for (int i = 0; i < 6; i++) src_u.mem[blk + i] = p[47 - 8 * i -: 8];
        @(posedge clk);
        reg_addr <= REG_DMA_ENABLE;
        reg_wdata <= 8'h01 << (b - 2);
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        fire(10'h001 << b, 1'b1);
        `CHK(ack_vector, v)
        n = 0;
        seen = 1'b0;
        while (busy === 1'b1 && n < 99) begin
            @(posedge clk);
            #1;
            n++;
            seen |= pc_load;
        end
        `CHK({src_u.mem[dst], src_u.mem[dst + 16'h1]}, {d0, m[2] ? d1 : ~d1})
        `CHK({seen, irq_enable_flag}, {c == 8'h01, c != 8'h01})
        if (c != 8'h01) `CHK(n, 45)
        else `CHK(pc_value, {8'h00, v})
        w = m[2] ? 16'h0002 : 16'h0001;
        dst += (m[1:0] == UPD_DST_INC) ? w : 16'h0000;
        src += (m[1:0] == UPD_SRC_INC) ? w : (m[1:0] == UPD_SRC_DEC) ? -w : 16'h0000;
        p = {c - 8'h01, dst[7:0], dst[15:8], src[7:0], src[15:8], 5'h00, m};
        `CHK(peek(blk), p)
    endtask : dma
    // Prints the counts and the verdict, then stops.
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    // Main sequence: reset, masking, priority chain, flag clear, DMA modes.
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        reg_read(REG_DMA_ENABLE);
        `CHK({rd, irq_enable_flag, busy, irq_ack}, {DMA_ENABLE_RESET, 12'h000})
        fire(10'h3FC, 1'b0);
        `CHK({irq_ack, busy}, 11'h000)
        reg_read(REG_PENDING_LO);
        `CHK(rd, 8'hFC)
        @(posedge clk);
        {enable_irq_instr, instr_boundary} <= 2'b11;
        @(posedge clk);
        {enable_irq_instr, instr_boundary, disable_irq_instr} <= 3'b001;
        #1 `CHK({irq_ack, busy, irq_enable_flag}, 12'h001)
        @(posedge clk);
        disable_irq_instr <= 1'b0;
        #1 `CHK(irq_enable_flag, 1'b0)
        serve(10'h002, 1, 1'b0, 1'b0);
        serve(10'h001, 0, 1'b1, 1'b1);
        for (int b = 2; b < NUM_SRC; b++) serve(10'h000, b, 1'b1, 1'b0);
        $display("entry test done");
        for (int m = 0; m < 8; m++) begin
            dma(m + 2, 3'(m), m == 0 ? 8'h00 : m == 5 ? 8'h01 : 8'h02 | 8'($random(seed)));
        end
        reg_read(REG_DMA_ENABLE);
        `CHK(rd, 8'h80)
        $display("dma test done");
        report_and_stop();
    end
endmodule : interrupt_and_micro_dma_sequencer_tb
bind irq_dma_sequencer irq_seq_chk chk_u (.*);

// ==== test/irq_seq_chk.sv ====
// Checker on the sequencer top ports.
// Assumes it is bound to the sequencer from the bench top file.
`timescale 1ns/10ps
module irq_seq_chk (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Watched ports.
    input wire logic [irq_seq_pkg::NUM_SRC-1:0] irq_req,
    input wire logic [irq_seq_pkg::NUM_SRC-1:0] irq_ack,
    input wire logic [7:0] ack_vector,
    input wire logic instr_boundary,
    input wire logic disable_irq_instr,
    input wire logic irq_enable_flag,
    input wire logic busy,
    input wire logic pc_load,
    input wire logic sp_load,
    input wire logic [15:0] pc_value,
    input wire logic mem_rd,
    input wire logic [15:0] mem_addr
);
    import irq_seq_pkg::*;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // An acknowledge marks acceptance; the next cycle tells entry from DMA.
    sequence taken_s; |irq_ack; endsequence
    sequence entry_s; taken_s ##1 !mem_rd; endsequence
    sequence dma_s; taken_s ##1 mem_rd; endsequence
    ack_order_a: assert property (taken_s |->
        irq_ack == ($past(irq_req) & (~$past(irq_req) + 10'h001))) else $error("bad order");
    ack_vector_a: assert property (taken_s |->
        irq_ack == (10'h001 << (ack_vector[7:3] - 5'h02))) else $error("bad vector");
    mask_gate_a: assert property (|irq_ack[9:2] |-> $past(irq_enable_flag))
        else $error("masked source taken");
    at_boundary_a: assert property (taken_s |-> $past(instr_boundary) && !$past(busy))
        else $error("taken off boundary");
    entry_len_a: assert property (entry_s |-> !irq_enable_flag && !pc_load [*8]
        ##11 pc_load && pc_value == {8'h00, ack_vector}) else $error("bad entry");
    dma_block_a: assert property (dma_s |-> mem_addr == PARAM_BASE + {8'h00, ack_vector})
        else $error("bad block address");
    dma_quiet_a: assert property (dma_s |->
        (!pc_load && !sp_load && $stable(irq_enable_flag)) [*8]) else $error("core touched");
    flag_clear_a: assert property (disable_irq_instr |=> !irq_enable_flag)
        else $error("flag not cleared");
endmodule : irq_seq_chk

// ==== test/irq_src_model.sv ====
// Model of the request sources and of the memory behind the bus.
// Assumes one clock; read data stand only in the cycle after the strobe.
`timescale 1ns/10ps
module irq_src_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Request side.
    input wire logic [irq_seq_pkg::NUM_SRC-1:0] raise,
    input wire logic [irq_seq_pkg::NUM_SRC-1:0] irq_ack,
    output logic [irq_seq_pkg::NUM_SRC-1:0] irq_req,
    // Memory side.
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_wr,
    input wire logic mem_rd,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:65535];
    // Requests hold until acknowledged; idle read data toggle so stale bytes never pass.
    always @(posedge clk) begin
        irq_req <= nrst ? (irq_req | raise) & ~irq_ack : 10'h000;
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
        mem_rdata <= !nrst ? 8'h00 : mem_rd ? mem[mem_addr] : ~mem_rdata;
    end
endmodule : irq_src_model
